// ===== logic/torque_map.svh
`ifndef TORQUE_MAP_SVH
`define TORQUE_MAP_SVH

// ==================================================================
// Register byte offsets
`define ADDR_CTRL          8'h00
`define ADDR_STATUS        8'h04
`define ADDR_FILTER        8'h08
`define ADDR_FULL_SCALE    8'h0C
`define ADDR_OFFSET        8'h10
`define ADDR_FPRESET_BASE  8'h14
`define ADDR_SPRESET_BASE  8'h20
`define ADDR_FORCE_CMD     8'h2C
`define ADDR_POS_BASE      8'h40
`define ADDR_POS_LAST      8'h5C

// ==================================================================
// Control register fields
`define CTRL_MODE_LSB      0
`define CTRL_ZERO_FORCE    4
`define CTRL_ZERO_SPEED    5
`define CTRL_FUNC_LSB      8

// ==================================================================
// Control mode settings
`define MODE_PULSE_POS     4'h1
`define MODE_STORED_POS    4'h2
`define MODE_SPEED         4'h3
`define MODE_FORCE         4'h4
`define MODE_PP_SPEED      4'h6
`define MODE_PP_FORCE      4'h7
`define MODE_SP_SPEED      4'h8
`define MODE_SP_FORCE      4'h9
`define MODE_SPEED_FORCE   4'hA

// ==================================================================
// Input function codes of the mode select pin
`define FUNC_NONE          5'h00
`define FUNC_POS_SPEED     5'h12
`define FUNC_SPEED_FORCE   5'h13
`define FUNC_POS_FORCE     5'h14

// ==================================================================
// Reset values
`define CTRL_RST           32'h0000_0004
`define FILTER_RST         4'h0
`define FULL_SCALE_RST     15'h0064
`define OFFSET_RST         16'h0000
`define PRESET_RST         16'h0000

// ==================================================================
// Analog scaling: full scale per 10 V, offset in millivolts
`define FS_VOLTS           40'sh00_0000_000A
`define MV_PER_V           40'sh00_0000_03E8

`endif

// ===== logic/torque_pkg.sv
package torque_pkg;

  typedef enum logic [1:0] {
    ST_SPEED    = 2'b00,
    ST_FORCE    = 2'b01,
    ST_POS_WAIT = 2'b10,
    ST_POS_MOVE = 2'b11
  } loop_state_t;

  typedef enum logic [1:0] {
    KIND_POS   = 2'b00,
    KIND_SPEED = 2'b01,
    KIND_FORCE = 2'b10
  } ctrl_kind_t;

endpackage : torque_pkg

// ===== logic/force_filter_if.sv
interface force_filter_if;
  logic signed [23:0] raw;
  logic        [3:0]  k;
  logic        [14:0] full_scale;
  logic signed [15:0] filt;

  modport src (output raw, output k, output full_scale, input filt);
  modport flt (input raw, input k, input full_scale, output filt);
endinterface : force_filter_if

// ===== logic/pos_table.sv
module pos_table #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock
  input  wire logic               clock,
  // Write port
  input  wire logic               wr_en,
  input  wire logic [WIDTH/8-1:0] wr_be,
  input  wire logic [AW-1:0]      wr_addr,
  input  wire logic [WIDTH-1:0]   wr_data,
  // Read ports, registered
  input  wire logic [AW-1:0]      rd_addr_a,
  output logic      [WIDTH-1:0]   rd_data_a,
  input  wire logic [AW-1:0]      rd_addr_b,
  output logic      [WIDTH-1:0]   rd_data_b
);

  // ==================================================================
  // One lane per byte so byte enables need no read-modify-write
  for (genvar b = 0; b < WIDTH / 8; b++) begin : g_lane
    logic [7:0] lane [DEPTH];

    always_ff @(posedge clock) begin
      if (wr_en && wr_be[b]) begin
        lane[wr_addr] <= wr_data[b*8 +: 8];
      end
      rd_data_a[b*8 +: 8] <= lane[rd_addr_a];
      rd_data_b[b*8 +: 8] <= lane[rd_addr_b];
    end
  end

endmodule : pos_table

// ===== logic/force_filter.sv
module force_filter (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Filter channel
  force_filter_if.flt     ch
);

  logic signed [23:0] acc_r;
  logic signed [23:0] acc_nxt;
  logic signed [15:0] out_r;
  logic signed [15:0] out_nxt;
  logic signed [23:0] lim;
  logic signed [23:0] nlim;

  // ==================================================================
  // First-order low-pass, clamp on the smoothed value
  always_comb begin
    lim  = $signed({9'h000, ch.full_scale});
    nlim = -lim;
    if (ch.k == 4'h0) begin
      acc_nxt = ch.raw;
    end else begin
      acc_nxt = acc_r + ((ch.raw - acc_r) >>> ch.k);
    end
    // The raw input is not clamped, so limit the smoothed value afterwards
    if (acc_r > lim) begin
      out_nxt = lim[15:0];
    end else if (acc_r < nlim) begin
      out_nxt = nlim[15:0];
    end else begin
      out_nxt = acc_r[15:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= 24'h00_0000;
      out_r <= 16'h0000;
    end else begin
      acc_r <= acc_nxt;
      out_r <= out_nxt;
    end
  end

  assign ch.filt = out_r;

endmodule : force_filter

// ===== logic/torque_select.sv
`include "torque_map.svh"

module torque_select (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               reset_n,
  // Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // Analog references, millivolts
  input  wire logic signed [15:0] force_analog_mv,
  input  wire logic signed [15:0] speed_analog_in,
  // Digital inputs
  input  wire logic               servo_enable,
  input  wire logic               force_source_sel0,
  input  wire logic               force_source_sel1,
  input  wire logic               speed_source_sel0,
  input  wire logic               speed_source_sel1,
  input  wire logic               pos_speed_mode_select,
  input  wire logic               cmd_trigger,
  input  wire logic [2:0]         pos_select,
  // Commands out
  output logic      [1:0]         ctrl_kind,
  output logic signed [15:0]      force_value,
  output logic                    force_is_limit,
  output logic signed [15:0]      speed_value,
  output logic      [31:0]        pos_target,
  output logic                    pos_hold,
  output logic                    pos_moving,
  output logic                    pos_from_pulse
);

  localparam int SI_FS0  = 0;
  localparam int SI_FS1  = 1;
  localparam int SI_SS0  = 2;
  localparam int SI_SS1  = 3;
  localparam int SI_MSEL = 4;
  localparam int SI_TRIG = 5;
  localparam int SI_EN   = 6;
  localparam int SI_PSEL = 7;
  localparam int SYNC_W  = 10;
  localparam logic signed [39:0] SCALE_DIV = `FS_VOLTS * `MV_PER_V;

  // Index 0..2 of a three-word preset group, 3 when outside it
  function automatic logic [1:0] preset_index(input logic [7:0] adr, input logic [7:0] base);
    logic [7:0] off;
    off = adr - base;
    if (adr >= base && off <= 8'h08) begin
      preset_index = off[3:2];
    end else begin
      preset_index = 2'h3;
    end
  endfunction : preset_index

  // ==================================================================
  // Input synchronisers
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic              trig_prev_r;
  logic              trig_rise;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_r      <= 10'h000;
      sync_r      <= 10'h000;
      trig_prev_r <= 1'b0;
    end else begin
      meta_r      <= {pos_select, servo_enable, cmd_trigger, pos_speed_mode_select,
                      speed_source_sel1, speed_source_sel0,
                      force_source_sel1, force_source_sel0};
      sync_r      <= meta_r;
      trig_prev_r <= sync_r[SI_TRIG];
    end
  end

  assign trig_rise = sync_r[SI_TRIG] && !trig_prev_r;

  // ==================================================================
  // Registers and bus slave
  logic        [31:0] ctrl_r;
  logic        [31:0] ctrl_nxt;
  logic        [3:0]  filter_r;
  logic        [3:0]  filter_nxt;
  logic        [14:0] full_scale_r;
  logic        [14:0] full_scale_nxt;
  logic signed [15:0] offset_r;
  logic signed [15:0] offset_nxt;
  logic signed [15:0] fpreset_r   [3];
  logic signed [15:0] fpreset_nxt [3];
  logic signed [15:0] spreset_r   [3];
  logic signed [15:0] spreset_nxt [3];
  logic               ack_r;
  logic               ack_nxt;
  logic               wait_r;
  logic               wait_nxt;
  logic        [31:0] dat_r;
  logic        [31:0] dat_nxt;
  logic        [31:0] rd_mux;
  logic        [31:0] wr_word;
  logic        [31:0] status;
  logic        [31:0] tbl_rd_a;
  logic        [31:0] tbl_rd_b;
  logic               req;
  logic               tbl_hit;
  logic               tbl_wr;
  logic        [7:0]  adr;
  logic        [1:0]  fp_idx;
  logic        [1:0]  sp_idx;

  torque_pkg::loop_state_t state_r;
  torque_pkg::loop_state_t state_nxt;
  torque_pkg::ctrl_kind_t  kind_r;
  torque_pkg::ctrl_kind_t  kind_nxt;
  logic                    pulse_r;
  logic                    pulse_nxt;

  assign adr     = {wb_adr_i[7:2], 2'b00};
  assign req     = wb_cyc_i && wb_stb_i && !ack_r;
  assign tbl_hit = adr >= `ADDR_POS_BASE && adr <= `ADDR_POS_LAST;
  assign fp_idx  = preset_index(adr, `ADDR_FPRESET_BASE);
  assign sp_idx  = preset_index(adr, `ADDR_SPRESET_BASE);
  assign status  = {26'h000_0000, pulse_r, sync_r[SI_EN], state_r, kind_r};

  always_comb begin
    if (adr == `ADDR_CTRL) begin
      rd_mux = ctrl_r;
    end else if (adr == `ADDR_STATUS) begin
      rd_mux = status;
    end else if (adr == `ADDR_FILTER) begin
      rd_mux = {28'h000_0000, filter_r};
    end else if (adr == `ADDR_FULL_SCALE) begin
      rd_mux = {17'h0_0000, full_scale_r};
    end else if (adr == `ADDR_OFFSET) begin
      rd_mux = {16'h0000, offset_r};
    end else if (fp_idx != 2'h3) begin
      rd_mux = {16'h0000, fpreset_r[fp_idx]};
    end else if (sp_idx != 2'h3) begin
      rd_mux = {16'h0000, spreset_r[sp_idx]};
    end else if (adr == `ADDR_FORCE_CMD) begin
      rd_mux = {16'h0000, force_value};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_word[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : rd_mux[b*8 +: 8];
    end
  end

  always_comb begin
    ctrl_nxt       = ctrl_r;
    filter_nxt     = filter_r;
    full_scale_nxt = full_scale_r;
    offset_nxt     = offset_r;
    fpreset_nxt    = fpreset_r;
    spreset_nxt    = spreset_r;
    dat_nxt        = dat_r;
    ack_nxt        = 1'b0;
    wait_nxt       = 1'b0;
    tbl_wr         = 1'b0;
    if (req) begin
      // Table reads need one extra cycle for the registered memory
      if (tbl_hit && !wb_we_i && !wait_r) begin
        wait_nxt = 1'b1;
      end else begin
        ack_nxt = 1'b1;
        if (!wb_we_i) begin
          dat_nxt = tbl_hit ? tbl_rd_a : rd_mux;
        end else if (adr == `ADDR_CTRL) begin
          ctrl_nxt = wr_word;
        end else if (adr == `ADDR_FILTER) begin
          filter_nxt = wr_word[3:0];
        end else if (adr == `ADDR_FULL_SCALE) begin
          full_scale_nxt = wr_word[14:0];
        end else if (adr == `ADDR_OFFSET) begin
          offset_nxt = wr_word[15:0];
        end else if (fp_idx != 2'h3) begin
          fpreset_nxt[fp_idx] = wr_word[15:0];
        end else if (sp_idx != 2'h3) begin
          spreset_nxt[sp_idx] = wr_word[15:0];
        end else if (tbl_hit) begin
          tbl_wr = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r       <= `CTRL_RST;
      filter_r     <= `FILTER_RST;
      full_scale_r <= `FULL_SCALE_RST;
      offset_r     <= `OFFSET_RST;
      fpreset_r    <= '{default: `PRESET_RST};
      spreset_r    <= '{default: `PRESET_RST};
      ack_r        <= 1'b0;
      wait_r       <= 1'b0;
      dat_r        <= 32'h0000_0000;
    end else begin
      ctrl_r       <= ctrl_nxt;
      filter_r     <= filter_nxt;
      full_scale_r <= full_scale_nxt;
      offset_r     <= offset_nxt;
      fpreset_r    <= fpreset_nxt;
      spreset_r    <= spreset_nxt;
      ack_r        <= ack_nxt;
      wait_r       <= wait_nxt;
      dat_r        <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  pos_table #(.WIDTH(32), .DEPTH(8), .AW(3)) u_pos_table (
    .clock     (clock),
    .wr_en     (tbl_wr),
    .wr_be     (wb_sel_i),
    .wr_addr   (adr[4:2]),
    .wr_data   (wb_dat_i),
    .rd_addr_a (adr[4:2]),
    .rd_data_a (tbl_rd_a),
    .rd_addr_b (sync_r[SI_PSEL +: 3]),
    .rd_data_b (tbl_rd_b)
  );

  // ==================================================================
  // Analog force scaling and filter
  force_filter_if     fch ();
  logic signed [16:0] diff_mv;
  logic signed [39:0] prod;
  logic signed [39:0] quot;

  always_comb begin
    diff_mv = 17'(force_analog_mv) - 17'(offset_r);
    prod    = 40'(diff_mv) * $signed({25'h000_0000, full_scale_r});
    quot    = prod / SCALE_DIV;
  end

  assign fch.raw        = quot[23:0];
  assign fch.k          = filter_r;
  assign fch.full_scale = full_scale_r;

  force_filter u_force_filter (
    .clock   (clock),
    .reset_n (reset_n),
    .ch      (fch)
  );

  // ==================================================================
  // Control mode selection
  logic [3:0]             mode;
  logic [4:0]             need_func;
  logic                   msel;
  logic                   stored;
  torque_pkg::ctrl_kind_t kind0;
  torque_pkg::ctrl_kind_t kind1;
  torque_pkg::ctrl_kind_t want;
  logic                   load_r;
  logic                   load_nxt;

  assign mode = ctrl_r[`CTRL_MODE_LSB +: 4];

  always_comb begin
    need_func = `FUNC_NONE;
    kind0     = torque_pkg::KIND_SPEED;
    kind1     = torque_pkg::KIND_SPEED;
    stored    = 1'b0;
    case (mode)
      `MODE_PP_SPEED, `MODE_SP_SPEED: begin
        need_func = `FUNC_POS_SPEED;
        kind1     = torque_pkg::KIND_POS;
        stored    = mode == `MODE_SP_SPEED;
      end
      `MODE_PP_FORCE, `MODE_SP_FORCE: begin
        need_func = `FUNC_POS_FORCE;
        kind0     = torque_pkg::KIND_FORCE;
        kind1     = torque_pkg::KIND_POS;
        stored    = mode == `MODE_SP_FORCE;
      end
      `MODE_SPEED_FORCE: begin
        need_func = `FUNC_SPEED_FORCE;
        kind1     = torque_pkg::KIND_FORCE;
      end
      `MODE_PULSE_POS, `MODE_STORED_POS: begin
        kind0  = torque_pkg::KIND_POS;
        kind1  = torque_pkg::KIND_POS;
        stored = mode == `MODE_STORED_POS;
      end
      `MODE_FORCE: begin
        kind0 = torque_pkg::KIND_FORCE;
        kind1 = torque_pkg::KIND_FORCE;
      end
      default: begin
        kind0 = torque_pkg::KIND_SPEED;
      end
    endcase
    // Unassigned pin or disabled servo leaves the dual mode in mode 0
    msel = need_func != `FUNC_NONE
        && ctrl_r[`CTRL_FUNC_LSB +: 5] == need_func
        && sync_r[SI_EN] && sync_r[SI_MSEL];
    want = msel ? kind1 : kind0;
  end

  always_comb begin
    state_nxt = state_r;
    load_nxt  = 1'b0;
    case (want)
      torque_pkg::KIND_POS: begin
        if (!stored) begin
          state_nxt = torque_pkg::ST_POS_MOVE;
        end else if (trig_rise && state_r != torque_pkg::ST_SPEED
                     && state_r != torque_pkg::ST_FORCE) begin
          state_nxt = torque_pkg::ST_POS_MOVE;
          load_nxt  = 1'b1;
        end else if (state_r == torque_pkg::ST_SPEED || state_r == torque_pkg::ST_FORCE) begin
          state_nxt = torque_pkg::ST_POS_WAIT;
        end
      end
      torque_pkg::KIND_FORCE: begin
        state_nxt = torque_pkg::ST_FORCE;
      end
      default: begin
        state_nxt = torque_pkg::ST_SPEED;
      end
    endcase
  end

  // ==================================================================
  // Command outputs
  logic        [1:0]  fcode;
  logic        [1:0]  scode;
  logic signed [15:0] force_nxt;
  logic signed [15:0] speed_nxt;
  logic        [31:0] target_nxt;

  assign fcode = {sync_r[SI_FS1], sync_r[SI_FS0]};
  assign scode = {sync_r[SI_SS1], sync_r[SI_SS0]};

  always_comb begin
    if (fcode != 2'b00) begin
      force_nxt = fpreset_r[fcode - 2'b01];
    end else if (ctrl_r[`CTRL_ZERO_FORCE]) begin
      force_nxt = 16'h0000;
    end else begin
      force_nxt = fch.filt;
    end
    if (scode != 2'b00) begin
      speed_nxt = spreset_r[scode - 2'b01];
    end else if (ctrl_r[`CTRL_ZERO_SPEED]) begin
      speed_nxt = 16'h0000;
    end else begin
      speed_nxt = speed_analog_in;
    end
    target_nxt = load_r ? tbl_rd_b : pos_target;
    pulse_nxt  = state_nxt == torque_pkg::ST_POS_MOVE && !stored;
    case (state_nxt)
      torque_pkg::ST_FORCE: kind_nxt = torque_pkg::KIND_FORCE;
      torque_pkg::ST_SPEED: kind_nxt = torque_pkg::KIND_SPEED;
      default:              kind_nxt = torque_pkg::KIND_POS;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r        <= torque_pkg::ST_SPEED;
      kind_r         <= torque_pkg::KIND_SPEED;
      pulse_r        <= 1'b0;
      load_r         <= 1'b0;
      force_value    <= 16'h0000;
      force_is_limit <= 1'b1;
      speed_value    <= 16'h0000;
      pos_target     <= 32'h0000_0000;
    end else begin
      state_r        <= state_nxt;
      kind_r         <= kind_nxt;
      pulse_r        <= pulse_nxt;
      load_r         <= load_nxt;
      force_value    <= force_nxt;
      force_is_limit <= state_nxt != torque_pkg::ST_FORCE;
      speed_value    <= speed_nxt;
      pos_target     <= target_nxt;
    end
  end

  assign ctrl_kind      = kind_r;
  assign pos_hold       = state_r == torque_pkg::ST_POS_WAIT;
  assign pos_moving     = state_r == torque_pkg::ST_POS_MOVE;
  assign pos_from_pulse = pulse_r;

endmodule : torque_select

// ===== tb/host_model.sv
module host_model (
  // Clock
  input  wire logic         clock,
  // Enable, force sel 1..0, speed sel 1..0, mode, trigger, position index
  output logic [9:0]        pins,
  // Analog references in millivolts
  output logic signed [15:0] force_analog_mv,
  output logic signed [15:0] speed_analog_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins stand for inputs given function codes 14..20
  initial begin
    pins = 10'h000;
    force_analog_mv = 16'sh0000;
    speed_analog_in = 16'sh0000;
  end
  task automatic set_pins(input logic [9:0] v);
    @(posedge clock);
    pins <= v;
  endtask : set_pins
  task automatic set_spd(input logic signed [15:0] v);
    @(posedge clock);
    speed_analog_in <= v;
  endtask : set_spd
  task automatic set_mv(input logic signed [15:0] v);
    @(posedge clock);
    force_analog_mv <= v;
  endtask : set_mv
endmodule : host_model

// ===== tb/torque_select_sva.sv
module torque_select_sva (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Commands
  input wire logic        cmd_trigger,
  input wire logic [1:0]  ctrl_kind,
  input wire logic        force_is_limit,
  input wire logic        pos_hold,
  input wire logic        pos_moving,
  input wire logic [31:0] pos_target
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_DAT_HOLD: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read answer");
  AST_LIMIT_KIND: assert property (force_is_limit == (ctrl_kind != torque_pkg::KIND_FORCE))
    else $error("limit flag disagrees with control kind");
  AST_HOLD_STATE: assert property (pos_hold |-> !pos_moving && ctrl_kind == torque_pkg::KIND_POS)
    else $error("hold outside position wait");
  AST_MOVE_KIND: assert property (pos_moving |-> ctrl_kind == torque_pkg::KIND_POS)
    else $error("moving outside position control");
  AST_TRIG_IGNORED: assert property (ctrl_kind != torque_pkg::KIND_POS &&
    $past(ctrl_kind) != torque_pkg::KIND_POS |-> $stable(pos_target))
    else $error("target changed outside position control");
  AST_HOLD_NO_TRIG: assert property ((pos_hold && !cmd_trigger)[*4] |=> !pos_moving)
    else $error("motion started without trigger");
  AST_MOVE_FROM_TRIG: assert property ($rose(pos_moving) && $past(pos_hold) |->
    $past(cmd_trigger, 3) && !$past(cmd_trigger, 4))
    else $error("motion not tied to a trigger rise");
  cover property ($rose(pos_moving));
  cover property (ctrl_kind == torque_pkg::KIND_FORCE);
  cover property (wb_ack_o && !wb_we_i);
endmodule : torque_select_sva

bind torque_select torque_select_sva torque_select_sva_inst (
  .clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .cmd_trigger(cmd_trigger),
  .ctrl_kind(ctrl_kind), .force_is_limit(force_is_limit), .pos_hold(pos_hold),
  .pos_moving(pos_moving), .pos_target(pos_target)
);

// ===== tb/torque_select_tb_top.sv
`include "torque_map.svh"

module torque_select_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic               clock, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]         wb_adr_i;
  logic [31:0]        wb_dat_i, wb_dat_o, rd, pos_target;
  logic [9:0]         pins;
  logic [3:0]         wb_sel_i, lanes;
  logic [1:0]         ctrl_kind;
  logic               force_is_limit, pos_hold, pos_moving, pos_from_pulse;
  logic signed [15:0] force_analog_mv, speed_analog_in, force_value, speed_value;
  logic [15:0]        fp [4], ao [5], am [5], ae [5], cfg [7];
  logic [3:0]         kinds [7];
  int                 fail_count = 0, comparisons = 0, cycles = 0;

  host_model host_model_inst (.clock(clock), .pins(pins), .force_analog_mv(force_analog_mv),
    .speed_analog_in(speed_analog_in));
  torque_select torque_select_inst (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .force_analog_mv(force_analog_mv), .speed_analog_in(speed_analog_in),
    .servo_enable(pins[9]), .force_source_sel1(pins[8]), .force_source_sel0(pins[7]),
    .speed_source_sel1(pins[6]), .speed_source_sel0(pins[5]),
    .pos_speed_mode_select(pins[4]), .cmd_trigger(pins[3]), .pos_select(pins[2:0]),
    .ctrl_kind(ctrl_kind), .force_value(force_value), .force_is_limit(force_is_limit),
    .speed_value(speed_value), .pos_target(pos_target), .pos_hold(pos_hold),
    .pos_moving(pos_moving), .pos_from_pulse(pos_from_pulse));

  // ======
  // Tasks
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : check
  task automatic wb_rw(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= lanes;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_sel_i <= 4'h0;
    if (n >= 50) check("bus ack", 32'h1, 32'h0);
  endtask : wb_rw
  task automatic reg_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb_rw(1'b0, a, 32'h0);
    check(name, exp, rd);
  endtask : reg_chk
  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask : settle

  // ======
  // Clock, timeout, sequence
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    fp = '{16'h0000, 16'h0096, 16'hFF38, 16'h012C};
    ao = '{16'h0000, 16'h03E8, 16'hEC78, 16'h1388, 16'h0000};
    am = '{16'h1388, 16'h1388, 16'h2710, 16'hD8F0, 16'hFEB3};
    ae = '{16'h0032, 16'h0028, 16'h0064, 16'hFF9C, 16'hFFFD};
    cfg = '{16'h1206, 16'h1407, 16'h1208, 16'h1409, 16'h130A, 16'h0008, 16'h1408};
    kinds = '{4'h4, 4'h8, 4'h4, 4'h8, 4'h6, 4'h5, 4'h5};
    reset_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    lanes = 4'hF;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    reg_chk("ctrl", `ADDR_CTRL, `CTRL_RST);
    reg_chk("full scale", `ADDR_FULL_SCALE, {17'h00000, `FULL_SCALE_RST});
    lanes = 4'h2;
    wb_rw(1'b1, `ADDR_OFFSET, 32'hFFFF_ABCD);
    lanes = 4'hF;
    reg_chk("byte lane", `ADDR_OFFSET, 32'h0000_AB00);
    wb_rw(1'b1, 8'h34, 32'hFFFF_FFFF);
    reg_chk("unmapped", 8'h34, 32'h0);
    $display("test registers done");
    for (int i = 1; i < 4; i++) wb_rw(1'b1, `ADDR_FPRESET_BASE + 8'(4 * i - 4), {16'h0, fp[i]});
    for (int i = 1; i < 4; i++) begin
      host_model_inst.set_pins({1'b1, 2'(i), 7'h00});
      settle(4);
      check("force preset", {16'h0, fp[i]}, {16'h0, force_value});
      check("limit flag", 32'h0, {31'h0, force_is_limit});
      reg_chk("force cmd", `ADDR_FORCE_CMD, {16'h0, fp[i]});
    end
    wb_rw(1'b1, `ADDR_CTRL, 32'h0000_0003);
    settle(6);
    check("preset as limit", {15'h0, 1'b1, fp[3]}, {15'h0, force_is_limit, force_value});
    $display("test presets done");
    wb_rw(1'b1, `ADDR_CTRL, 32'h0000_0004);
    host_model_inst.set_pins(10'h200);
    for (int i = 0; i < 5; i++) begin
      wb_rw(1'b1, `ADDR_OFFSET, {16'h0, ao[i]});
      host_model_inst.set_mv(am[i]);
      settle(6);
      check("analog force", {16'h0, ae[i]}, {16'h0, force_value});
    end
    wb_rw(1'b1, `ADDR_CTRL, 32'h0000_0014);
    settle(6);
    check("zero force", 32'h0, {16'h0, force_value});
    wb_rw(1'b1, `ADDR_CTRL, 32'h0000_0004);
    wb_rw(1'b1, `ADDR_OFFSET, 32'h0);
    host_model_inst.set_mv(16'sh0000);
    wb_rw(1'b1, `ADDR_FILTER, 32'h2);
    host_model_inst.set_mv(16'sh2710);
    settle(4);
    check("smoothing", 32'h1, {31'h0, force_value < 16'sh0064});
    settle(100);
    check("smoothed end", 32'h1, {31'h0, force_value >= 16'sh0061});
    wb_rw(1'b1, `ADDR_FILTER, 32'h0);
    $display("test analog done");
    for (int i = 0; i < 7; i++) begin
      wb_rw(1'b1, `ADDR_CTRL, {16'h0, cfg[i]});
      host_model_inst.set_pins(10'h200);
      settle(6);
      check("kind select 0", {30'h0, kinds[i][3:2]}, {30'h0, ctrl_kind});
      host_model_inst.set_pins(10'h210);
      settle(6);
      check("kind select 1", {30'h0, kinds[i][1:0]}, {30'h0, ctrl_kind});
      check("pulse source", {31'h0, kinds[i][1:0] == 2'b00 && cfg[i][1]},
        {31'h0, pos_from_pulse});
    end
    wb_rw(1'b1, `ADDR_CTRL, 32'h0000_1208);
    host_model_inst.set_pins(10'h010);
    settle(6);
    check("disabled kind", 32'h1, {30'h0, ctrl_kind});
    $display("test dual modes done");
    wb_rw(1'b1, `ADDR_POS_BASE + 8'h04, 32'h1234_5678);
    reg_chk("table", `ADDR_POS_BASE + 8'h04, 32'h1234_5678);
    wb_rw(1'b1, `ADDR_SPRESET_BASE, 32'h0000_01F4);
    host_model_inst.set_pins(10'h22F);
    settle(6);
    check("speed preset", 32'h01F4, {16'h0, speed_value});
    check("trigger ignored", 32'h0, pos_target);
    host_model_inst.set_pins(10'h231);
    settle(8);
    check("held", 32'h1, {29'h0, ctrl_kind, pos_hold});
    host_model_inst.set_pins(10'h239);
    settle(7);
    check("moving", 32'h1, {31'h0, pos_moving});
    check("target", 32'h1234_5678, pos_target);
    host_model_inst.set_pins(10'h221);
    settle(4);
    check("back to speed", 32'h1, {30'h0, ctrl_kind});
    wb_rw(1'b1, `ADDR_SPRESET_BASE + 8'h08, 32'h0000_FF06);
    host_model_inst.set_spd(16'sh0123);
    host_model_inst.set_pins(10'h261);
    settle(4);
    check("speed preset three", 32'hFF06, {16'h0, speed_value});
    host_model_inst.set_pins(10'h201);
    settle(4);
    check("analog speed", 32'h0123, {16'h0, speed_value});
    $display("test position done");
    print_verdict();
  end
endmodule : torque_select_tb_top
